// *** rtl/sbio_pkg.sv ***
// Shared constants for the serial bit I/O bridge: serial timing, pin map,
// command codes, reply codes, the start-up banner and the control states.
// Assumes a single 40 MHz system clock.
package sbio_pkg;
	// System clock rate in hertz.
	localparam int CLK_HZ = 40_000_000;
	// Serial link rate in bits per second, and the cycles in one bit.
	localparam int BAUD_BPS = 57600;
	localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
	// Slow and fast status pulse half periods in milliseconds.
	localparam int PULSE_SLOW_MS = 500;
	localparam int PULSE_FAST_MS = 100;
	localparam int PULSE_SLOW_CYC = (CLK_HZ / 1000) * PULSE_SLOW_MS;
	localparam int PULSE_FAST_CYC = (CLK_HZ / 1000) * PULSE_FAST_MS;
	// Least time between two-wire bus edges, in nanoseconds.
	localparam int TW_STEP_NS = 5000;
	localparam int TW_STEP_CYC = (CLK_HZ / 1_000_000) * TW_STEP_NS / 1000;
	// Pin count and the zero-based positions of the special pins.
	localparam int NPINS = 11;
	localparam int PULSE_PIN = 2;
	localparam int SCL_PIN = 9;
	localparam int SDA_PIN = 10;
	// Level register value after reset: only the status pin bit is high.
	localparam logic [10:0] LVL_RESET = 11'h004;
	// Serial frame bit positions: start is 0, stop is 9.
	localparam logic [3:0] FRAME_START = 4'h0;
	localparam logic [3:0] FRAME_STOP = 4'h9;
	// Command opcodes held in the high nibble of the first byte.
	localparam logic [3:0] OP_RD = 4'he;
	localparam logic [3:0] OP_WR = 4'hf;
	// Whole first-byte commands.
	localparam logic [7:0] CMD_TW_START = 8'ha0;
	localparam logic [7:0] CMD_TW_STOP = 8'ha3;
	localparam logic [7:0] CMD_PULSE_EN = 8'hc0;
	localparam logic [7:0] CMD_PULSE_RATE = 8'hc1;
	localparam logic [7:0] CMD_REV = 8'hc2;
	// Reply codes.
	localparam logic [7:0] ACK_TW_START = 8'hb0;
	localparam logic [7:0] ACK_TW_STOP = 8'hb3;
	localparam logic [7:0] ACK_PULSE_EN = 8'hd0;
	localparam logic [7:0] ACK_PULSE_RATE = 8'hd1;
	localparam logic [7:0] ACK_REV = 8'hd2;
	localparam logic [7:0] ACK_WR = 8'hf0;
	localparam logic [7:0] REPLY_ERR = 8'hfa;
	localparam logic [7:0] LVL_LO = 8'h00;
	localparam logic [7:0] LVL_HI = 8'h01;
	// Revision bytes; the values are arbitrary.
	localparam logic [7:0] REV_MAJOR = 8'h01;
	localparam logic [7:0] REV_MINOR = 8'h00;
	// Start-up banner text; the value is arbitrary.
	localparam int BANNER_LEN = 8;
	localparam logic [2:0] BANNER_LAST = 3'(BANNER_LEN - 1);
	localparam logic [7:0] BANNER [0:7] = '{8'h42, 8'h49, 8'h4f, 8'h20,
		8'h76, 8'h31, 8'h2e, 8'h30};
	// Index of the last step of the two-wire sequence.
	localparam logic [1:0] TW_LAST_STEP = 2'h3;
	// Control states.
	typedef enum logic [4:0] {
		SBIO_BANNER = 5'h01,
		SBIO_CMD1 = 5'h02,
		SBIO_CMD2 = 5'h04,
		SBIO_STEP = 5'h08,
		SBIO_REPLY = 5'h10
	} sbio_state_t;
endpackage : sbio_pkg

// *** rtl/sbio_bridge.sv ***
// Serial bit I/O bridge: serial receiver and transmitter, command decoder,
// eleven pin drivers, status pulse generator and two-wire start and stop.
// Assumes RXD, PIN_IN synchronous to CLK; RST_B follows the host's DTR.
`timescale 1ns/10ps
module sbio_bridge import sbio_pkg::*; #(
	parameter int BIT_CYC_P = BIT_CYC,
	parameter int PULSE_SLOW_P = PULSE_SLOW_CYC,
	parameter int PULSE_FAST_P = PULSE_FAST_CYC
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic RXD,
	output logic TXD,
	input wire logic [10:0] PIN_IN,
	output logic [10:0] PIN_OUT,
	output logic [10:0] PIN_OE
);
	// Cycle reloads for one bit and for half a bit.
	localparam logic [15:0] BIT_M1 = 16'(BIT_CYC_P - 1);
	localparam logic [15:0] HALF_M1 = 16'(BIT_CYC_P / 2 - 1);

	// Tells whether a pin address names one of the eleven pins.
	function automatic logic pin_ok(input logic [3:0] a);
		pin_ok = (a != 4'h0) && (a <= 4'(NPINS));
	endfunction : pin_ok

	// Receiver state: busy flag, cycle count, frame bit, shift register.
	logic rx_busy_reg, rx_busy_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0] rx_bit_reg, rx_bit_next;
	logic [7:0] rx_sh_reg, rx_sh_next;
	logic rx_valid_reg, rx_valid_next;
	// Transmitter state and the line level it drives.
	logic tx_busy_reg, tx_busy_next;
	logic [15:0] tx_cnt_reg, tx_cnt_next;
	logic [3:0] tx_bit_reg, tx_bit_next;
	logic [9:0] tx_sh_reg, tx_sh_next;
	logic txd_reg, txd_next;
	// Load strobe and byte from the control logic.
	logic tx_go;
	logic [7:0] tx_data;
	// Status pulse state.
	logic [25:0] pls_cnt_reg, pls_cnt_next;
	logic pls_lvl_reg, pls_lvl_next;
	// Control state: FSM, indices, command, replies, pin settings.
	sbio_state_t state_reg, state_next;
	logic [2:0] idx_reg, idx_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [2:0][7:0] resp_reg, resp_next;
	logic [2:0] rlast_reg, rlast_next;
	logic pulse_en_reg, pulse_en_next;
	logic pulse_fast_reg, pulse_fast_next;
	logic [10:0] lvl_reg, lvl_next;
	logic [10:0] drv_reg, drv_next;
	logic tw_mode_reg, tw_mode_next;
	logic tw_scl_reg, tw_scl_next;
	logic tw_sda_reg, tw_sda_next;
	logic [1:0] step_reg, step_next;
	logic [15:0] step_cnt_reg, step_cnt_next;
	// Level of the pin that the current command addresses.
	logic rd_bit;
	logic [3:0] pin_idx;

	assign pin_idx = cmd_reg[3:0] - 4'h1;
	assign rd_bit = PIN_IN[pin_idx];
	assign TXD = txd_reg;

	// serial bit timing
	// Receiver: 8N1 frames, each bit sampled in its middle.
	always_comb begin
		rx_busy_next = rx_busy_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next = rx_sh_reg;
		rx_valid_next = 1'b0;
		if (!rx_busy_reg) begin
			// A low line begins a frame.
			if (!RXD) begin
				rx_busy_next = 1'b1;
				rx_cnt_next = HALF_M1;
				rx_bit_next = FRAME_START;
			end
		end else if (rx_cnt_reg != 16'h0000) begin
			rx_cnt_next = rx_cnt_reg - 16'h0001;
		end else begin
			rx_cnt_next = BIT_M1;
			rx_bit_next = rx_bit_reg + 4'h1;
			if (rx_bit_reg == FRAME_START) begin
				// A glitch that is high again at mid bit is dropped.
				rx_busy_next = !RXD;
			end else if (rx_bit_reg == FRAME_STOP) begin
				// A frame without a valid stop bit is discarded.
				rx_busy_next = 1'b0;
				rx_valid_next = RXD;
			end else begin
				rx_sh_next = {RXD, rx_sh_reg[7:1]};
			end
		end
	end

	// serial bit timing
	// Transmitter: start bit, eight data bits LSB first, stop bit.
	always_comb begin
		tx_busy_next = tx_busy_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_bit_next = tx_bit_reg;
		tx_sh_next = tx_sh_reg;
		txd_next = txd_reg;
		if (tx_go) begin
			tx_busy_next = 1'b1;
			tx_sh_next = {1'b1, tx_data, 1'b0};
			tx_cnt_next = BIT_M1;
			tx_bit_next = FRAME_START;
			txd_next = 1'b0;
		end else if (tx_busy_reg) begin
			if (tx_cnt_reg != 16'h0000) begin
				tx_cnt_next = tx_cnt_reg - 16'h0001;
			end else if (tx_bit_reg == FRAME_STOP) begin
				tx_busy_next = 1'b0;
				txd_next = 1'b1;
			end else begin
				tx_sh_next = {1'b1, tx_sh_reg[9:1]};
				txd_next = tx_sh_reg[1];
				tx_bit_next = tx_bit_reg + 4'h1;
				tx_cnt_next = BIT_M1;
			end
		end
	end

	// Status pulse: half period counter that toggles the pulse level.
	always_comb begin
		pls_cnt_next = pls_cnt_reg - 26'h1;
		pls_lvl_next = pls_lvl_reg;
		if (pls_cnt_reg == 26'h0) begin
			pls_lvl_next = !pls_lvl_reg;
			pls_cnt_next = pulse_fast_reg ? 26'(PULSE_FAST_P - 1) :
				26'(PULSE_SLOW_P - 1);
		end
	end

	// Control: banner, command bytes, execution, replies.
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		cmd_next = cmd_reg;
		resp_next = resp_reg;
		rlast_next = rlast_reg;
		pulse_en_next = pulse_en_reg;
		pulse_fast_next = pulse_fast_reg;
		lvl_next = lvl_reg;
		drv_next = drv_reg;
		tw_mode_next = tw_mode_reg;
		tw_scl_next = tw_scl_reg;
		tw_sda_next = tw_sda_reg;
		step_next = step_reg;
		step_cnt_next = step_cnt_reg;
		tx_go = 1'b0;
		tx_data = resp_reg[idx_reg[1:0]];
		unique case (state_reg)
			SBIO_BANNER: begin
				tx_data = BANNER[idx_reg];
				tx_go = !tx_busy_reg;
				if (tx_go) begin
					idx_next = idx_reg + 3'h1;
					if (idx_reg == BANNER_LAST) begin
						state_next = SBIO_CMD1;
					end
				end
			end
			SBIO_CMD1: begin
				// First byte selects the command.
				if (rx_valid_reg) begin
					cmd_next = rx_sh_reg;
					state_next = SBIO_CMD2;
				end
			end
			SBIO_CMD2: begin
				if (rx_valid_reg) begin
					state_next = SBIO_REPLY;
					idx_next = 3'h0;
					rlast_next = 3'h0;
					resp_next[0] = REPLY_ERR;
					if (cmd_reg == CMD_PULSE_EN &&
						rx_sh_reg[7:1] == 7'h00) begin
						pulse_en_next = rx_sh_reg[0];
						resp_next[0] = ACK_PULSE_EN;
					end else if (cmd_reg == CMD_PULSE_RATE &&
						rx_sh_reg[7:1] == 7'h00) begin
						pulse_fast_next = rx_sh_reg[0];
						resp_next[0] = ACK_PULSE_RATE;
					end else if (cmd_reg == CMD_REV) begin
						resp_next = {ACK_REV, REV_MINOR, REV_MAJOR};
						rlast_next = 3'h2;
					end else if (cmd_reg == CMD_TW_START ||
						(cmd_reg == CMD_TW_STOP && tw_mode_reg)) begin
						tw_mode_next = 1'b1;
						state_next = SBIO_STEP;
						step_next = 2'h0;
						step_cnt_next = 16'(TW_STEP_CYC - 1);
						resp_next[0] = (cmd_reg == CMD_TW_START) ?
							ACK_TW_START : ACK_TW_STOP;
					end else if (cmd_reg[7:4] == OP_RD &&
						pin_ok(cmd_reg[3:0])) begin
						resp_next[0] = rd_bit ? LVL_HI : LVL_LO;
					end else if (cmd_reg[7:4] == OP_WR &&
						pin_ok(cmd_reg[3:0]) &&
						rx_sh_reg[7:1] == 7'h00) begin
						lvl_next[pin_idx] = rx_sh_reg[0];
						drv_next[pin_idx] = 1'b1;
						resp_next[0] = ACK_WR;
					end
				end
			end
			SBIO_STEP: begin
				// At most one bus edge each step time, four steps in all.
				if (step_cnt_reg != 16'h0000) begin
					step_cnt_next = step_cnt_reg - 16'h0001;
				end else begin
					step_cnt_next = 16'(TW_STEP_CYC - 1);
					step_next = step_reg + 2'h1;
					if (cmd_reg == CMD_TW_START) begin
						// Release both, then data falls before clock.
						unique case (step_reg)
							2'h0: tw_sda_next = 1'b1;
							2'h1: tw_scl_next = 1'b1;
							2'h2: tw_sda_next = 1'b0;
							2'h3: tw_scl_next = 1'b0;
						endcase
					end else begin
						// Data low, clock up, then data rises.
						unique case (step_reg)
							2'h0: tw_sda_next = 1'b0;
							2'h1: tw_scl_next = 1'b1;
							2'h2: tw_sda_next = 1'b1;
							2'h3: tw_sda_next = 1'b1;
						endcase
					end
					if (step_reg == TW_LAST_STEP) begin
						state_next = SBIO_REPLY;
					end
				end
			end
			SBIO_REPLY: begin
				tx_go = !tx_busy_reg;
				if (tx_go) begin
					idx_next = idx_reg + 3'h1;
					if (idx_reg == rlast_reg) begin
						state_next = SBIO_CMD1;
					end
				end
			end
		endcase
	end

	// Pin drivers.
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			if (i == PULSE_PIN) begin
				PIN_OUT[i] = 1'b0;
				PIN_OE[i] = pulse_en_reg ? !pls_lvl_reg : !lvl_reg[i];
			end else if (tw_mode_reg && (i == SCL_PIN || i == SDA_PIN)) begin
				PIN_OUT[i] = 1'b0;
				PIN_OE[i] = (i == SCL_PIN) ? !tw_scl_reg : !tw_sda_reg;
			end else begin
				PIN_OUT[i] = lvl_reg[i];
				PIN_OE[i] = drv_reg[i];
			end
		end
	end

	// Registers; release of the DTR reset starts the banner.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 4'h0;
			rx_sh_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			tx_busy_reg <= 1'b0;
			tx_cnt_reg <= 16'h0000;
			tx_bit_reg <= 4'h0;
			tx_sh_reg <= 10'h3ff;
			txd_reg <= 1'b1;
			pls_cnt_reg <= 26'h0;
			pls_lvl_reg <= 1'b0;
			state_reg <= SBIO_BANNER;
			idx_reg <= 3'h0;
			cmd_reg <= 8'h00;
			resp_reg <= '0;
			rlast_reg <= 3'h0;
			pulse_en_reg <= 1'b1;
			pulse_fast_reg <= 1'b0;
			lvl_reg <= LVL_RESET;
			drv_reg <= 11'h000;
			tw_mode_reg <= 1'b0;
			tw_scl_reg <= 1'b1;
			tw_sda_reg <= 1'b1;
			step_reg <= 2'h0;
			step_cnt_reg <= 16'h0000;
		end else begin
			rx_busy_reg <= rx_busy_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg <= rx_sh_next;
			rx_valid_reg <= rx_valid_next;
			tx_busy_reg <= tx_busy_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_bit_reg <= tx_bit_next;
			tx_sh_reg <= tx_sh_next;
			txd_reg <= txd_next;
			pls_cnt_reg <= pls_cnt_next;
			pls_lvl_reg <= pls_lvl_next;
			state_reg <= state_next;
			idx_reg <= idx_next;
			cmd_reg <= cmd_next;
			resp_reg <= resp_next;
			rlast_reg <= rlast_next;
			pulse_en_reg <= pulse_en_next;
			pulse_fast_reg <= pulse_fast_next;
			lvl_reg <= lvl_next;
			drv_reg <= drv_next;
			tw_mode_reg <= tw_mode_next;
			tw_scl_reg <= tw_scl_next;
			tw_sda_reg <= tw_sda_next;
			step_reg <= step_next;
			step_cnt_reg <= step_cnt_next;
		end
	end

	// Checks on the behaviour above.
	chk_banner_first: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(RST_B) |-> state_reg == SBIO_BANNER && tx_go)
		else $error("banner not started after reset");
	chk_inputs_reset: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(RST_B) |-> PIN_OE == {8'h00, !pls_lvl_reg, 2'h0})
		else $error("pins not inputs after reset");
	chk_pulse_default: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(RST_B) |-> pulse_en_reg && !pulse_fast_reg)
		else $error("pulse not slow and on after reset");
	chk_pulse_toggle: assert property (@(posedge CLK) disable iff (!RST_B)
		pls_cnt_reg == 26'h0 |=> pls_lvl_reg != $past(pls_lvl_reg) &&
		pls_cnt_reg == 26'(($past(pulse_fast_reg) ? PULSE_FAST_P :
		PULSE_SLOW_P) - 1))
		else $error("pulse did not toggle or reload");
	chk_status_pull: assert property (@(posedge CLK) disable iff (!RST_B)
		!pulse_en_reg && !lvl_reg[PULSE_PIN] |-> PIN_OE[PULSE_PIN] &&
		!PIN_OUT[PULSE_PIN])
		else $error("status pin not pulled down");
	chk_start_bit: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(tx_busy_reg) |-> !TXD [*8])
		else $error("start bit too short");
	chk_error_reply: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == SBIO_CMD2 && rx_valid_reg && cmd_reg[7:4] == OP_RD &&
		!pin_ok(cmd_reg[3:0]) |=> resp_reg[0] == REPLY_ERR &&
		state_reg == SBIO_REPLY)
		else $error("invalid read not refused");
	chk_read_reply: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == SBIO_CMD2 && rx_valid_reg && cmd_reg[7:4] == OP_RD &&
		pin_ok(cmd_reg[3:0]) |=> resp_reg[0] == {7'h00, $past(rd_bit)})
		else $error("pin read reply wrong");
	chk_write_ack: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == SBIO_CMD2 && rx_valid_reg && cmd_reg[7:4] == OP_WR &&
		pin_ok(cmd_reg[3:0]) && rx_sh_reg == LVL_HI |=>
		resp_reg[0] == ACK_WR && lvl_reg[pin_idx])
		else $error("pin write not applied");
	chk_tw_drain: assert property (@(posedge CLK) disable iff (!RST_B)
		tw_mode_reg |-> !PIN_OUT[SCL_PIN] && !PIN_OUT[SDA_PIN])
		else $error("two-wire line driven high");
endmodule : sbio_bridge

// *** bench/sbio_host.sv ***
// Host side model: sends command frames on the serial line and
// collects the reply frames that the bridge transmits.
// Assumes 8N1 framing with the bit time given in clock cycles.
`timescale 1ns/10ps
module sbio_host #(
	parameter int BIT_P = 16
) (
	input wire logic CLK,
	output logic rxd,
	input wire logic txd,
	output logic [7:0] rx_byte,
	output logic rx_stop,
	output logic rx_stb
);
	// The line idles high, at the mark level, between frames.
	initial begin
		rxd = 1'b1;
		rx_stb = 1'b0;
		rx_byte = 8'h00;
		rx_stop = 1'b1;
	end
	// command frame timing
	// Sends one frame, low bit first, each bit held BIT_P cycles.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge CLK);
			rxd <= fr[i];
			repeat (BIT_P - 1) @(posedge CLK);
		end
	endtask : send_byte
	// reply bit timing
	// Samples each reply bit mid-bit and pulses rx_stb when it samples the stop bit mid-bit.
	initial begin
		forever begin
			@(posedge CLK);
			rx_stb <= 1'b0;
			if (txd === 1'b0) begin
				repeat (BIT_P / 2) @(posedge CLK);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_P) @(posedge CLK);
					rx_byte[i] <= txd;
				end
				repeat (BIT_P) @(posedge CLK);
				rx_stop <= txd;
				rx_stb <= 1'b1;
			end
		end
	end
endmodule : sbio_host

// *** bench/sbio_bridge_bench.sv ***
// Self-checking bench for the serial bit I/O bridge.
// Assumes short bit and pulse counts; pins 3, 10 and 11 have pullups.
`timescale 1ns/10ps
module sbio_bridge_bench import sbio_pkg::*;;
	localparam int BIT_T = 16;
	localparam int SLOW_T = 50;
	localparam int FAST_T = 10;
	// Clock, reset and serial lines.
	// The clock starts low so that no false edge appears at time zero.
	logic CLK = 1'b0;
	logic RST_B, RXD, TXD, rx_stop, rx_stb;
	// Pin outputs, resolved levels, outside drive and written-pin model.
	logic [10:0] PIN_OUT, PIN_OE, pin_w, ext, wr_m, wv_m;
	logic [7:0] rx_byte;
	// Expected reply bytes, oldest first.
	logic [7:0] exp_q[$];
	logic tw_on, od_hi;
	int num_errors, checked;
	// Commands that must be refused.
	logic [15:0] bad[8] = '{16'he000, 16'hec00, 16'hf001, 16'hf102,
		16'ha300, 16'h5500, 16'hc002, 16'hc102};
	// Driven pins show their drive, released pins their pullup or ext.
	// status load tolerates pulsing
	// The load on the status pin takes any pulse train without harm.
	assign pin_w = (PIN_OE & PIN_OUT) | (~PIN_OE & (11'h604 | ext));
	// An open-drain pin that drives high is an error.
	assign od_hi = (PIN_OE[2] & PIN_OUT[2])
		| (tw_on & |(PIN_OE[10:9] & PIN_OUT[10:9]));
	sbio_bridge #(.BIT_CYC_P(BIT_T), .PULSE_SLOW_P(SLOW_T),
		.PULSE_FAST_P(FAST_T)) u_sbio_bridge (.CLK(CLK), .RST_B(RST_B),
		.RXD(RXD), .TXD(TXD), .PIN_IN(pin_w), .PIN_OUT(PIN_OUT),
		.PIN_OE(PIN_OE));
	sbio_host #(.BIT_P(BIT_T)) u_sbio_host (.CLK(CLK), .rxd(RXD),
		.txd(TXD), .rx_byte(rx_byte), .rx_stop(rx_stop), .rx_stb(rx_stb));
	// The 40 MHz clock.
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// Counts a comparison and reports a difference at once.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// Expected level of a pin from the bench's own pin model.
	function automatic logic lvl(input int b);
		if (wr_m[b]) return wv_m[b];
		if (b == 2 || b == 9 || b == 10) return 1'b1;
		return ext[b];
	endfunction : lvl
	// Waits, bounded, until every expected reply byte has arrived.
	task automatic drain();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 4000) begin
			@(posedge CLK);
			k++;
		end
		// A reply that never came is a failure, not a silent pass.
		check(16'(exp_q.size()), 16'h0);
		exp_q.delete();
		repeat (2 * BIT_T) @(posedge CLK);
	endtask : drain
	// Sends one command with one expected reply byte.
	task automatic cmd(input logic [7:0] b1, b2, r);
		exp_q.push_back(r);
		u_sbio_host.send_byte(b1);
		u_sbio_host.send_byte(b2);
		drain();
	endtask : cmd
	// Holds reset four cycles, checks the idle pins, expects the banner.
	task automatic do_reset();
		RST_B <= 1'b0;
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		check({TXD, PIN_OE}, 16'h0804);
		check(16'(PIN_OUT), 16'h0);
		wr_m = '0;
		tw_on = 1'b0;
		for (int i = 0; i < BANNER_LEN; i++) begin
			exp_q.push_back(BANNER[i]);
		end
		@(posedge CLK);
		RST_B <= 1'b1;
		drain();
	endtask : do_reset
	// Measures one full half period of the status pulse.
	task automatic pulse_half(input int n);
		logic s;
		int c;
		@(negedge CLK);
		for (int j = 0; j < 2; j++) begin
			s = PIN_OE[2];
			c = 0;
			while (PIN_OE[2] === s && c < 400) begin
				@(negedge CLK);
				c++;
			end
		end
		check(16'(c), 16'(n));
	endtask : pulse_half
	// Compares each reply byte with the oldest note.
	always @(posedge CLK) begin
		if (rx_stb === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(16'(rx_byte), 16'h1ff);
			end else begin
				check({7'h0, rx_stop, rx_byte}, {8'h1, exp_q.pop_front()});
			end
		end
	end
	// Watches the open-drain pins every cycle.
	always @(negedge CLK) begin
		check(16'(od_hi), 16'h0);
	end
	// Cuts a hang short.
	initial begin
		repeat (90000) @(posedge CLK);
		num_errors++;
		final_report();
	end
	// Main sequence.
	initial begin
		RST_B = 1'b0;
		ext = '0;
		wv_m = '0;
		num_errors = 0;
		checked = 0;
		void'($urandom(32'h1fc6));
		do_reset();
		check(16'(PIN_OE & 11'h7fb), 16'h0);
		pulse_half(SLOW_T);
		cmd(CMD_PULSE_RATE, LVL_HI, ACK_PULSE_RATE);
		pulse_half(FAST_T);
		cmd(CMD_PULSE_RATE, LVL_LO, ACK_PULSE_RATE);
		pulse_half(SLOW_T);
		cmd(CMD_PULSE_EN, LVL_LO, ACK_PULSE_EN);
		@(posedge CLK);
		ext <= 11'($urandom);
		@(posedge CLK);
		// Reads every released pin except the status pin with random outside levels.
		for (int p = 1; p <= NPINS; p++) begin
			if (p != 3) cmd({OP_RD, 4'(p)}, 8'h00, {7'h0, lvl(p - 1)});
		end
		// Drives every pin low then high and reads it back.
		for (int p = 1; p <= NPINS; p++) begin
			for (int v = 0; v < 2; v++) begin
				cmd({OP_WR, 4'(p)}, 8'(v), ACK_WR);
				wr_m[p - 1] = 1'b1;
				wv_m[p - 1] = 1'(v);
				if (p != 3) check({PIN_OE[p - 1], PIN_OUT[p - 1]}, {1'b1, 1'(v)});
				cmd({OP_RD, 4'(p)}, 8'h00, {7'h0, lvl(p - 1)});
			end
		end
		foreach (bad[i]) cmd(bad[i][15:8], bad[i][7:0], REPLY_ERR);
		exp_q.push_back(REV_MAJOR);
		exp_q.push_back(REV_MINOR);
		cmd(CMD_REV, 8'h00, ACK_REV);
		cmd(CMD_TW_START, 8'h00, ACK_TW_START);
		tw_on = 1'b1;
		// After a start condition both bus lines are held low.
		check(16'(pin_w[10:9]), 16'h0);
		cmd(CMD_TW_STOP, 8'h00, ACK_TW_STOP);
		check(16'(pin_w[10:9]), 16'h3);
		do_reset();
		final_report();
	end
endmodule : sbio_bridge_bench
